//--- shared/qno_pkg.sv
// Shared widths, reset values and pin groups of the quadrature oscillator
package qno_pkg;

  // Data path widths
  localparam int FREQ_W  = 32;
  localparam int POFF_W  = 16;
  localparam int PHASE_W = 28;
  localparam int AMP_W   = 16;
  localparam int CBUS_W  = 16;
  localparam int ADDR_W  = 3;
  localparam int PSK_W   = 3;
  localparam int PSK_LOW = POFF_W - PSK_W;

  // Control register addresses on the write port
  localparam logic [2:0] ADR_CENTER_LO = 3'h0;
  localparam logic [2:0] ADR_CENTER_HI = 3'h1;
  localparam logic [2:0] ADR_OFFSET_LO = 3'h2;
  localparam logic [2:0] ADR_OFFSET_HI = 3'h3;
  localparam logic [2:0] ADR_PHASE_IN  = 3'h4;

  // Values after reset
  localparam logic [31:0] FREQ_RST  = 32'h0000_0000;
  localparam logic [15:0] POFF_RST  = 16'h0000;
  localparam logic [15:0] CBUS_RST  = 16'h0000;
  localparam logic [15:0] AMP_RST   = 16'h0000;
  localparam logic [27:0] PHASE_RST = 28'h000_0000;
  localparam logic [3:0]  BIT_RST   = 4'h0;
  localparam logic [3:0]  BIT_LAST  = 4'hf;

  // Quarter turn on the 16-bit lookup phase
  localparam logic [15:0] QUARTER   = 16'h4000;
  // Largest positive amplitude word
  localparam logic [14:0] AMP_MAX   = 15'h7fff;

  // Discrete control pins, all asynchronous to CLK
  typedef struct packed {
    logic             phase_offset_load_n;
    logic             offset_freq_load_n;
    logic             center_freq_load_n;
    logic             phase_acc_load_n;
    logic             phase_source_sel;
    logic             output_format_sel;
    logic             output_shape_sel;
    logic [PSK_W-1:0] psk_phase_sel;
  } qno_ctrl_s;

  // Host write port pins
  typedef struct packed {
    logic              wr_n;
    logic              cs_n;
    logic [ADDR_W-1:0] addr;
    logic [CBUS_W-1:0] data;
  } qno_wr_s;

  // Idle levels of the pin groups, used as synchroniser reset values
  localparam qno_ctrl_s CTRL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1,
                                      1'b1, 1'b1, 1'b1, 3'h0};
  localparam qno_wr_s   WR_IDLE   = '{1'b1, 1'b1, 3'h0, 16'h0000};

endpackage

//--- hdl/qno_sincos.sv
// Sine and cosine amplitude stage driven by the 28-bit phase word
`timescale 1ns/100ps
module qno_sincos
  import qno_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               NRST,
  input  wire logic               EN,
  input  wire logic [PHASE_W-1:0] PHASE,
  output logic      [AMP_W-1:0]   SINE,
  output logic      [AMP_W-1:0]   COSINE
);

  // Parabolic half-wave; cheaper than a full table, a few percent off
  function automatic logic [15:0] qno_wave(input logic [15:0] p);
    logic [15:0] u;
    logic [15:0] v;
    logic [31:0] prod;
    logic [14:0] mag;
    u    = {1'b0, p[14:0]};
    v    = 16'h8000 - u;
    prod = u * v;
    mag  = (prod[31:13] > {4'h0, AMP_MAX}) ? AMP_MAX : prod[27:13];
    qno_wave = p[15] ? (16'h0000 - {1'b0, mag}) : {1'b0, mag};
  endfunction

  logic [15:0] look_p;
  logic [15:0] look_c;

  // Lookup uses the top 16 of the 28 phase bits
  assign look_p = PHASE[PHASE_W-1 -: 16];
  assign look_c = look_p + QUARTER;

  // Both words come from the same phase in the same edge
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      SINE   <= AMP_RST;
      COSINE <= AMP_RST;
    end
    else if (EN)
    begin
      SINE   <= qno_wave(look_p);
      COSINE <= qno_wave(look_c);
    end
  end

endmodule // qno_sincos

//--- hdl/qno_osc.sv
// Phase and frequency control section with quadrature output stage
// Summary of operation
// - Center and offset frequency each held at 32 bits for coherent hops.
// - A 16-bit phase offset is added to the running phase.
// - Control section hands a 28-bit phase to the amplitude stage.
// - Sine and cosine words of 16 bits come from each phase together.
// - Output is parallel or serial, two's complement or offset binary.
// - Serial mode drives a strobe marking each word boundary.
// - Three modulation pins pick one of eight phase states directly.
// - Host presents a 16-bit control word, bit zero least significant.
// - A 3-bit address picks the control register written; host holds it.
// - Writes are taken only while the low-active chip select is low.
// - Control word loads on rising edge of the write strobe.
// - All other registers update on clock edges; the working registers only when enabled.
// - Phase offset load enable is registered, then loads the offset.
// - Phase offset load updates lookup phase even with accumulator held.
// - Registered offset frequency enable loads that register each edge.
// - Registered center frequency enable loads that register each edge.
// - Source select picks phase input or modulation pins with low zeros.
// - Modulation pins give 0 to 315 degrees in 45 degree steps.
// - Format low inverts sine and cosine top bit for offset binary.
// - Parallel mode reloads outputs each clock; serial mode shifts.
`timescale 1ns/100ps
module qno_osc
  import qno_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire qno_ctrl_s        CTRL_PINS,
  input  wire qno_wr_s          WR_PINS,
  output logic      [AMP_W-1:0] SINE_OUT,
  output logic      [AMP_W-1:0] COSINE_OUT,
  output logic                  DAC_STROBE_N
);

  // Synchronised pin groups; each meta stage is read only by the
  // stage behind it, never by logic
  qno_ctrl_s          ctrl_meta_q;
  qno_ctrl_s          ctrl_q;
  qno_wr_s            wr_meta_q;
  qno_wr_s            wr_q;
  logic               wr_prev_q;
  logic               wr_rise;

  // Staging registers written by the host
  logic [FREQ_W-1:0]  center_stage_q;
  logic [FREQ_W-1:0]  offset_stage_q;
  logic [POFF_W-1:0]  phase_in_q;

  // Working registers on the main clock
  logic [FREQ_W-1:0]  center_freq_q;
  logic [FREQ_W-1:0]  offset_freq_q;
  logic [POFF_W-1:0]  phase_off_q;
  logic [FREQ_W-1:0]  phase_acc_q;
  logic [FREQ_W-1:0]  freq_sum;
  logic [POFF_W-1:0]  phase_off_d;
  logic [PHASE_W-1:0] look_phase_q;
  logic [PHASE_W-1:0] look_phase_d;
  logic               look_en;
  logic               look_src;
  logic               look_src_q;
  logic               look_en_q;

  // Amplitude words and output stage
  // Each word is kept twice so the two serial pins run apart
  logic [AMP_W-1:0]   sine_raw;
  logic [AMP_W-1:0]   cosine_raw;
  logic [AMP_W-1:0]   sine_fmt;
  logic [AMP_W-1:0]   cosine_fmt;
  logic [AMP_W-1:0]   sine_msb_q;
  logic [AMP_W-1:0]   sine_lsb_q;
  logic [AMP_W-1:0]   cosine_msb_q;
  logic [AMP_W-1:0]   cosine_lsb_q;
  logic [3:0]         bit_cnt_q;
  logic               serial_mode;

  // Control pins pass two flops; the second stage is the registered
  // copy that the logic below treats as each enable
  // The pins have no timing tie to CLK, so one flop alone could hand
  // a half-settled level to several enables at once
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_meta_q <= CTRL_IDLE;
      ctrl_q      <= CTRL_IDLE;
    end
    else
    begin
      ctrl_meta_q <= CTRL_PINS;
      ctrl_q      <= ctrl_meta_q;
    end
  end

  // Write port pins pass two flops as a group
  // Address and data stand still around the strobe, so a plain copy
  // of the whole bus is safe once the strobe edge is found
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_meta_q <= WR_IDLE;
      wr_q      <= WR_IDLE;
      wr_prev_q <= 1'b1;
    end
    else
    begin
      wr_meta_q <= WR_PINS;
      wr_q      <= wr_meta_q;
      wr_prev_q <= wr_q.wr_n;
    end
  end

  // Rising strobe seen on the synchronised copy; the host must keep
  // address and data steady a few clocks past the strobe edge
  // A strobe pulse shorter than one clock may be missed
  assign wr_rise = wr_q.wr_n & ~wr_prev_q;

  // Host writes land in the staging register chosen by the address
  // Each half lands alone, so a working register whose enable is low
  // during a two-part write can briefly copy a mixed value
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      center_stage_q <= FREQ_RST;
      offset_stage_q <= FREQ_RST;
      phase_in_q     <= POFF_RST;
    end
    else if (wr_rise && !wr_q.cs_n)
    begin
      case (wr_q.addr)
        ADR_CENTER_LO: center_stage_q[15:0]  <= wr_q.data;
        ADR_CENTER_HI: center_stage_q[31:16] <= wr_q.data;
        ADR_OFFSET_LO: offset_stage_q[15:0]  <= wr_q.data;
        ADR_OFFSET_HI: offset_stage_q[31:16] <= wr_q.data;
        ADR_PHASE_IN:  phase_in_q            <= wr_q.data;
        // Spare addresses 5 to 7 hold nothing here
        default:       phase_in_q            <= phase_in_q;
      endcase
    end
  end

  // Center frequency reloads on every edge its enable is low
  // The enable is a level: holding it low keeps copying the stage
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      center_freq_q <= FREQ_RST;
    else if (!ctrl_q.center_freq_load_n)
      center_freq_q <= center_stage_q;
  end

  // Offset frequency reloads on every edge its enable is low
  // Same level behaviour as the center register
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      offset_freq_q <= FREQ_RST;
    else if (!ctrl_q.offset_freq_load_n)
      offset_freq_q <= offset_stage_q;
  end

  // Phase offset source: host word or modulation pins over zeros;
  // each pin step is one eighth turn, i.e. 45 degrees
  // The select is registered with the same lag as the load enable
  always_comb
  begin
    if (ctrl_q.phase_source_sel)
      phase_off_d = phase_in_q;
    else
      phase_off_d = {ctrl_q.psk_phase_sel,
                     {PSK_LOW{1'b0}}};
  end

  // Phase offset register, loaded while its registered enable is low
  // One enabled clock is enough; the lookup catches up one edge
  // later through the enable history below
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      phase_off_q <= POFF_RST;
    else if (!ctrl_q.phase_offset_load_n)
      phase_off_q <= phase_off_d;
  end

  // Sum of both frequencies; a hop only changes the step, so the
  // accumulated phase carries on without a jump
  // Carry out of the top bit is dropped on purpose
  assign freq_sum = center_freq_q + offset_freq_q;

  // Phase accumulator wraps naturally at its width
  // A high enable freezes the phase; the lookup then moves only on offset loads
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      phase_acc_q <= FREQ_RST;
    else if (!ctrl_q.phase_acc_load_n)
      phase_acc_q <= phase_acc_q + freq_sum;
  end

  // Lookup phase: top 28 accumulator bits plus the phase offset
  // Offset sits in the top 16 bits: one step is 1/65536 turn
  assign look_phase_d = phase_acc_q[FREQ_W-1 -: PHASE_W]
                      + {phase_off_q, {(PHASE_W-POFF_W){1'b0}}};

  // Offset loads move the lookup even while the accumulator holds.
  // Offset and accumulator change on the edge their enable is seen,
  // so the lookup needs one more edge to take the final value; a
  // one-clock offset load would otherwise never reach the outputs
  assign look_src = !ctrl_q.phase_acc_load_n
                  | !ctrl_q.phase_offset_load_n;
  assign look_en  = look_src | look_src_q;

  // Enable history for the lookup and amplitude steps
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      look_src_q <= 1'b0;
      look_en_q  <= 1'b0;
    end
    else
    begin
      look_src_q <= look_src;
      look_en_q  <= look_en;
    end
  end

  // Lookup register; holds while no source of phase moves, so the
  // outputs stay still in parallel mode with every enable off
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      look_phase_q <= PHASE_RST;
    else if (look_en)
      look_phase_q <= look_phase_d;
  end

  // Amplitude stage, fed the 28-bit phase word
  // It registers one edge behind the lookup, so it takes the
  // delayed enable and still sees the last lookup value
  qno_sincos u_sincos
  (
    .CLK    (CLK),
    .NRST   (NRST),
    .EN     (look_en_q),
    .PHASE  (look_phase_q),
    .SINE   (sine_raw),
    .COSINE (cosine_raw)
  );

  // Offset binary is two's complement with the sign bit flipped
  // Applied ahead of the shifters so both shapes carry one code
  always_comb
  begin
    sine_fmt   = sine_raw;
    cosine_fmt = cosine_raw;
    if (!ctrl_q.output_format_sel)
    begin
      sine_fmt[AMP_W-1]   = ~sine_raw[AMP_W-1];
      cosine_fmt[AMP_W-1] = ~cosine_raw[AMP_W-1];
    end
  end

  // Serial whenever the registered shape select is low
  assign serial_mode = !ctrl_q.output_shape_sel;

  // Bit counter frames the 16-bit serial word
  // Free running: the word boundary has no tie to the accumulator
  // enable, so a converter must frame on the strobe alone
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      bit_cnt_q <= BIT_RST;
    else if (serial_mode)
      bit_cnt_q <= bit_cnt_q + 4'h1;
    else
      bit_cnt_q <= BIT_RST;
  end

  // Two shifters per channel: one for the MSB-first stream on the top
  // pin, one for the LSB-first stream on the bottom pin
  // Loading only at count zero keeps a word from tearing mid-shift,
  // at the cost of up to one word of lag after a phase change
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sine_msb_q   <= AMP_RST;
      sine_lsb_q   <= AMP_RST;
      cosine_msb_q <= AMP_RST;
      cosine_lsb_q <= AMP_RST;
    end
    else if (!serial_mode || bit_cnt_q == BIT_RST)
    begin
      sine_msb_q   <= sine_fmt;
      sine_lsb_q   <= sine_fmt;
      cosine_msb_q <= cosine_fmt;
      cosine_lsb_q <= cosine_fmt;
    end
    else
    begin
      sine_msb_q   <= {sine_msb_q[AMP_W-2:0], 1'b0};
      sine_lsb_q   <= {1'b0, sine_lsb_q[AMP_W-1:1]};
      cosine_msb_q <= {cosine_msb_q[AMP_W-2:0], 1'b0};
      cosine_lsb_q <= {1'b0, cosine_lsb_q[AMP_W-1:1]};
    end
  end

  // Output pins from flops; in serial mode only the end pins carry
  // data, the middle pins rest at zero
  // Straight from flops so the converter sees clean edges and the
  // shape switch takes effect on one edge for all pins
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      SINE_OUT   <= AMP_RST;
      COSINE_OUT <= AMP_RST;
    end
    else if (!serial_mode)
    begin
      SINE_OUT   <= sine_msb_q;
      COSINE_OUT <= cosine_msb_q;
    end
    else
    begin
      SINE_OUT   <= {sine_msb_q[AMP_W-1], {(AMP_W-2){1'b0}},
                     sine_lsb_q[0]};
      COSINE_OUT <= {cosine_msb_q[AMP_W-1], {(AMP_W-2){1'b0}},
                     cosine_lsb_q[0]};
    end
  end

  // Strobe low with the first bit of each word; high in parallel mode
  // Count one marks the edge at which the first bit reaches the pins,
  // so strobe and first bit leave their flops together
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      DAC_STROBE_N <= 1'b1;
    else
      DAC_STROBE_N <= !(serial_mode && bit_cnt_q == 4'h1);
  end

endmodule // qno_osc

//--- testbench/qno_osc_properties.sv
// Concurrent checks on the oscillator output pins
`timescale 1ns/100ps
module qno_osc_properties
  import qno_pkg::*;
(
  input wire logic             CLK,
  input wire logic             NRST,
  input wire qno_ctrl_s        CTRL_PINS,
  input wire qno_wr_s          WR_PINS,
  input wire logic [AMP_W-1:0] SINE_OUT,
  input wire logic [AMP_W-1:0] COSINE_OUT,
  input wire logic             DAC_STROBE_N
);
  logic [7:0] ser_q;
  logic [7:0] par_q;
  logic [7:0] idl_q;
  logic [7:0] fq_q;
  logic       fmt_q;
  wire        idle = &{CTRL_PINS.phase_offset_load_n,
                       CTRL_PINS.offset_freq_load_n,
                       CTRL_PINS.center_freq_load_n,
                       CTRL_PINS.phase_acc_load_n,
                       CTRL_PINS.output_shape_sel};

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  function automatic logic [7:0] sat(input logic [7:0] v);
    return v + {7'h00, ~&v};
  endfunction

  // Pin run lengths; margins cover the core's sync lag
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ser_q <= 8'h00;
      par_q <= 8'h00;
      idl_q <= 8'h00;
      fq_q  <= 8'h00;
      fmt_q <= 1'b1;
    end
    else
    begin
      ser_q <= CTRL_PINS.output_shape_sel ? 8'h00 : sat(ser_q);
      par_q <= CTRL_PINS.output_shape_sel ? sat(par_q) : 8'h00;
      idl_q <= idle ? sat(idl_q) : 8'h00;
      fmt_q <= CTRL_PINS.output_format_sel;
      fq_q  <= (CTRL_PINS.output_format_sel == fmt_q) ? sat(fq_q) : 8'h00;
    end
  end

  property p_par_strobe;
    par_q > 8'h04 |-> DAC_STROBE_N;
  endproperty
  a_par_strobe: assert property (p_par_strobe)
    else $error("strobe low in parallel mode");
  property p_ser_mid;
    ser_q > 8'h08 |-> SINE_OUT[14:1] == 14'h0000
      && COSINE_OUT[14:1] == 14'h0000;
  endproperty
  a_ser_mid: assert property (p_ser_mid)
    else $error("middle bits busy in serial mode");
  property p_strobe_period;
    !DAC_STROBE_N && ser_q inside {[8'h14:8'h3c]} |-> ##16 !DAC_STROBE_N;
  endproperty
  a_strobe_period: assert property (p_strobe_period)
    else $error("serial word not 16 cycles");
  property p_strobe_gap;
    ser_q > 8'h08 && !DAC_STROBE_N |=> DAC_STROBE_N [*8];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("strobe low twice within a word");
  property p_strobe_seen;
    ser_q == 8'h1e |-> ##[0:15] !DAC_STROBE_N;
  endproperty
  a_strobe_seen: assert property (p_strobe_seen)
    else $error("no word strobe in serial mode");
  property p_hold;
    idl_q > 8'h08 && fq_q > 8'h08 |-> $stable(SINE_OUT) && $stable(COSINE_OUT);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved with all enables off");
  property p_fmt_flip;
    idl_q > 8'h08 && fq_q > 8'h08 && $changed(CTRL_PINS.output_format_sel)
      |-> ##5 SINE_OUT == ($past(SINE_OUT, 5) ^ 16'h8000)
      && COSINE_OUT == ($past(COSINE_OUT, 5) ^ 16'h8000);
  endproperty
  a_fmt_flip: assert property (p_fmt_flip)
    else $error("format change did not flip only the top bit");
  property p_rst_out;
    $rose(NRST) |-> SINE_OUT == AMP_RST && COSINE_OUT == AMP_RST
      && DAC_STROBE_N;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not at reset value");

  // Main scenarios reached
  c_serial: cover property (!DAC_STROBE_N && ser_q > 8'h14);
  c_flip: cover property (idl_q > 8'h08 && $changed(CTRL_PINS.output_format_sel));
  c_hold: cover property (idl_q > 8'h08 && fq_q > 8'h08);
endmodule // qno_osc_properties

bind qno_osc qno_osc_properties qno_osc_properties_inst (
  .CLK          (CLK),
  .NRST         (NRST),
  .CTRL_PINS    (CTRL_PINS),
  .WR_PINS      (WR_PINS),
  .SINE_OUT     (SINE_OUT),
  .COSINE_OUT   (COSINE_OUT),
  .DAC_STROBE_N (DAC_STROBE_N)
);

//--- testbench/qno_host_model.sv
// Host processor model driving the control word port
`timescale 1ns/100ps
module qno_host_model
  import qno_pkg::*;
(
  input  wire logic CLK,
  output qno_wr_s   WR_PINS
);
  initial WR_PINS = WR_IDLE;

  // One write; pins move only just after rising edges
  task automatic write(input logic [ADDR_W-1:0] a,
                       input logic [CBUS_W-1:0] d,
                       input logic              cs_n);
    @(posedge CLK);
    WR_PINS.cs_n <= cs_n;
    WR_PINS.addr <= a;
    WR_PINS.data <= d;
    repeat (2) @(posedge CLK);
    WR_PINS.wr_n <= 1'b0;
    repeat (3) @(posedge CLK);
    WR_PINS.wr_n <= 1'b1;
    repeat (3) @(posedge CLK);
    // Released bus shows junk, never the old word
    WR_PINS <= '{1'b1, 1'b1, ~a, ~d};
    @(posedge CLK);
  endtask
endmodule // qno_host_model

//--- testbench/qno_osc_tb.sv
// Self-checking bench for the quadrature oscillator
`timescale 1ns/100ps
module qno_osc_tb
  import qno_pkg::*;
;
  logic             CLK;
  logic             NRST;
  qno_ctrl_s        CTRL_PINS;
  qno_wr_s          WR_PINS;
  logic [AMP_W-1:0] SINE_OUT;
  logic [AMP_W-1:0] COSINE_OUT;
  logic             DAC_STROBE_N;
  int               errors;
  int               tests_run;
  int               cyc = 0;
  logic [AMP_W-1:0] ps;
  logic [AMP_W-1:0] pc;
  logic [AMP_W-1:0] w [4];
  // Rows: psk code, format, sine, cosine
  logic [35:0]      rows [6] = '{
    {3'h2, 1'b0, 16'hffff, 16'h8000}, {3'h6, 1'b0, 16'h0001, 16'h8000},
    {3'h0, 1'b1, 16'h0000, 16'h7fff}, {3'h2, 1'b1, 16'h7fff, 16'h0000},
    {3'h4, 1'b1, 16'h0000, 16'h8001}, {3'h6, 1'b1, 16'h8001, 16'h0000}};

  qno_osc qno_osc_inst (
    .CLK          (CLK),
    .NRST         (NRST),
    .CTRL_PINS    (CTRL_PINS),
    .WR_PINS      (WR_PINS),
    .SINE_OUT     (SINE_OUT),
    .COSINE_OUT   (COSINE_OUT),
    .DAC_STROBE_N (DAC_STROBE_N)
  );
  qno_host_model qno_host_model_inst (
    .CLK     (CLK),
    .WR_PINS (WR_PINS)
  );

  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic chk(input logic [AMP_W-1:0] e, input logic [AMP_W-1:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Pulse the offset enable, then let the pipeline settle
  task automatic load_off(input logic [2:0] k, input logic f);
    @(posedge CLK);
    CTRL_PINS.psk_phase_sel       <= k;
    CTRL_PINS.output_format_sel   <= f;
    CTRL_PINS.phase_offset_load_n <= 1'b0;
    repeat (4) @(posedge CLK);
    CTRL_PINS.phase_offset_load_n <= 1'b1;
    repeat (10) @(posedge CLK);
    @(negedge CLK);
  endtask

  // Step of a quarter or half turn seen between neighbour samples
  task automatic spin(input logic half);
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    repeat (4)
    begin
      ps = SINE_OUT;
      pc = COSINE_OUT;
      @(negedge CLK);
      chk(half ? -ps : pc, SINE_OUT);
      chk(half ? -pc : -ps, COSINE_OUT);
    end
    @(posedge CLK);
  endtask

  // Hang guard, run needs well under 3000 cycles
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      close_out;
    end
  end

  initial
  begin
    errors    = 0;
    tests_run = 0;
    NRST      = 1'b0;
    CTRL_PINS = CTRL_IDLE;
    CTRL_PINS.phase_source_sel = 1'b0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk(AMP_RST, SINE_OUT);
    chk(16'h0001, {15'h0000, DAC_STROBE_N});
    @(posedge CLK);
    NRST <= 1'b1;
    foreach (rows[i])
    begin
      load_off(rows[i][35:33], rows[i][32]);
      chk(rows[i][31:16], SINE_OUT);
      chk(rows[i][15:0], COSINE_OUT);
    end
    // Odd eighths: equal or opposite magnitudes
    for (int k = 1; k < 8; k += 2)
    begin
      load_off(3'(k), 1'b1);
      chk(k[1] ? -COSINE_OUT : COSINE_OUT, SINE_OUT);
    end
    load_off(3'h2, 1'b1);
    @(posedge CLK);
    CTRL_PINS.output_format_sel <= 1'b0;
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    chk(16'hffff, SINE_OUT);
    @(posedge CLK);
    CTRL_PINS.output_format_sel <= 1'b1;
    repeat (12) @(posedge CLK);
    CTRL_PINS.output_shape_sel <= 1'b0;
    repeat (20) @(negedge CLK);
    for (int n = 0; n < 20 && DAC_STROBE_N !== 1'b0; n++)
      @(negedge CLK);
    for (int i = 0; i < 16; i++)
    begin
      w[0][15-i] = SINE_OUT[15];
      w[1][i]    = SINE_OUT[0];
      w[2][15-i] = COSINE_OUT[15];
      w[3][i]    = COSINE_OUT[0];
      @(negedge CLK);
    end
    chk(16'h7fff, w[0]);
    chk(16'h7fff, w[1]);
    chk(16'h0000, w[2]);
    chk(16'h0000, w[3]);
    repeat (60) @(posedge CLK);
    CTRL_PINS.output_shape_sel <= 1'b1;
    CTRL_PINS.phase_source_sel <= 1'b1;
    // Host phase word with the accumulator held
    qno_host_model_inst.write(ADR_PHASE_IN, 16'h4000, 1'b0);
    load_off(3'h0, 1'b1);
    chk(16'h7fff, SINE_OUT);
    qno_host_model_inst.write(ADR_PHASE_IN, 16'h8000, 1'b0);
    qno_host_model_inst.write(ADR_PHASE_IN, 16'h4000, 1'b1);
    qno_host_model_inst.write(3'h5, 16'h4000, 1'b0);
    load_off(3'h0, 1'b1);
    chk(16'h8001, COSINE_OUT);
    // One-clock offset load must still reach the outputs
    @(posedge CLK);
    CTRL_PINS.phase_source_sel    <= 1'b0;
    CTRL_PINS.psk_phase_sel       <= 3'h2;
    CTRL_PINS.phase_offset_load_n <= 1'b0;
    @(posedge CLK);
    CTRL_PINS.phase_offset_load_n <= 1'b1;
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    chk(16'h7fff, SINE_OUT);
    qno_host_model_inst.write(ADR_CENTER_HI, 16'h4000, 1'b0);
    @(posedge CLK);
    CTRL_PINS.center_freq_load_n <= 1'b0;
    CTRL_PINS.offset_freq_load_n <= 1'b0;
    CTRL_PINS.phase_acc_load_n   <= 1'b0;
    spin(1'b0);
    qno_host_model_inst.write(ADR_OFFSET_HI, 16'h4000, 1'b0);
    spin(1'b1);
    // Low halves: 0x4000_8000 plus 0x3fff_8000 is still a half turn
    qno_host_model_inst.write(ADR_CENTER_LO, 16'h8000, 1'b0);
    qno_host_model_inst.write(ADR_OFFSET_LO, 16'h8000, 1'b0);
    qno_host_model_inst.write(ADR_OFFSET_HI, 16'h3fff, 1'b0);
    spin(1'b1);
    qno_host_model_inst.write(ADR_OFFSET_HI, 16'h0000, 1'b1);
    spin(1'b1);
    close_out;
  end
endmodule // qno_osc_tb
